/* hw/plhcc_top.v */
// Clock control: PLL lock/filter flags, limp-home, monitor, reset, stop exit.
// Assumes synchronous status inputs and a single 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "plhcc_map.vh"
module plhcc_top (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Register port
  input wire [`PLHCC_ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  // Lock detector status
  input wire vcoInTrack,
  input wire vcoOutUntrack,
  input wire vcoInLock,
  input wire vcoOutUnlock,
  // Environment
  input wire pllSupply,
  input wire normalMode,
  input wire extClockPresent,
  input wire [5:0] slowDiv,
  // Stop control
  input wire stopReq,
  input wire extResetWake,
  input wire maskIrqWake,
  input wire nmiPinWake,
  input wire keyWakeA,
  input wire keyWakeB,
  input wire canWake,
  // Clock steering outputs
  output reg filterTrack,
  output reg pllPowerOn,
  output reg busClockFromPll,
  output reg moduleClockSelect,
  output reg forcePclkAll,
  output reg monitorActive,
  // Reset and interrupts
  output reg intResetN,
  output reg monitorReset,
  output reg lockIrq,
  output reg limpIrq,
  output reg stopped
);
  localparam ST_PORST = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_STOP = 4'b0100;
  localparam ST_EXIT = 4'b1000;

  reg rs1_q, rs2_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire rstN = rs2_q;

  reg [7:0] ctrl_q;
  reg lock_q, lockIf_q, lock_irq_enable_q, limp_home_active_q, limp_home_irq_flag_q, limp_home_irq_enable_q, dly_q;
  reg track_q;
  reg savBcsp_q, savMcs_q;
  reg noLimpLatch_q;
  reg [3:0] state_q;
  reg cntClear;
  wire tick, midHit;

  plhcc_divider uDiv (
    .clk(ref_clk),
    .rstN(rstN),
    .divSel(slowDiv),
    .tick(tick)
  );
  plhcc_counter uCnt (
    .clk(ref_clk),
    .rstN(rstN),
    .tick(tick),
    .clear(cntClear),
    .midHit(midHit)
  );

  wire autoMode = ctrl_q[`PLHCC_CTRL_AUTO];
  wire limpAvail = pllSupply; // [R8] [R21]
  wire monEn = limp_home_active_q | ctrl_q[`PLHCC_CTRL_CME] | ctrl_q[`PLHCC_CTRL_FORCED_MONITOR_ENABLE]; // [R10] [R14]
  wire clockLost = monEn & ~extClockPresent & (state_q == ST_RUN);
  wire enterLimp = clockLost & limpAvail & ~ctrl_q[`PLHCC_CTRL_NOLH] & ~limp_home_active_q; // [R12]
  wire lossReset = clockLost & (ctrl_q[`PLHCC_CTRL_NOLH] | ~limpAvail); // [R11]
  wire leaveLimp = limp_home_active_q & midHit & extClockPresent; // [R16]
  wire wake = extResetWake | maskIrqWake | nmiPinWake | keyWakeA | keyWakeB | canWake; // [R23]
  // Steering forced on the outputs, so power-up limp needs no register rewrite
  wire forceLimp = (limp_home_active_q | (state_q == ST_PORST)) & limpAvail; // [R12] [R14]

  // Filter mode: hardware hysteresis in auto, register in manual
  reg trackNext;
  always @* begin
    trackNext = track_q;
    if (autoMode) begin
      if (vcoInTrack)
        trackNext = 1'b1; // [R1] [R2]
      else if (vcoOutUntrack)
        trackNext = 1'b0; // [R2]
    end else if (regWr && regAddr == `PLHCC_REG_CTRL) begin
      trackNext = regWdata[`PLHCC_CTRL_TRACK]; // [R5] [R6]
    end
  end

  reg lockNext;
  always @* begin
    lockNext = lock_q;
    if (vcoInLock)
      lockNext = 1'b1; // [R3]
    else if (vcoOutUnlock)
      lockNext = 1'b0; // [R3]
  end

  wire flagWr = regWr && regAddr == `PLHCC_REG_FLAG;
  wire lhomeNext = (limp_home_active_q | enterLimp | (state_q == ST_PORST && midHit && limpAvail &&
    normalMode && !noLimpLatch_q && !extClockPresent)) & ~leaveLimp & limpAvail; // [R8]

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= `PLHCC_CTRL_RESET; // [R18]
      lock_q <= 1'b0;
      lockIf_q <= 1'b0;
      lock_irq_enable_q <= 1'b0;
      limp_home_active_q <= 1'b0;
      limp_home_irq_flag_q <= 1'b0;
      limp_home_irq_enable_q <= 1'b0;
      dly_q <= 1'b0;
      track_q <= 1'b0;
      savBcsp_q <= 1'b0;
      savMcs_q <= 1'b0;
      state_q <= ST_PORST;
    end else begin
      if (regWr && regAddr == `PLHCC_REG_CTRL) begin
        ctrl_q <= regWdata;
        if (limp_home_active_q) begin
          // Keep forced values live, remember software choice
          ctrl_q[`PLHCC_CTRL_PLL_POWER_ON] <= 1'b1;
          ctrl_q[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL] <= 1'b1;
          ctrl_q[`PLHCC_CTRL_MCS] <= 1'b0;
          savBcsp_q <= regWdata[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL]; // [R17]
          savMcs_q <= regWdata[`PLHCC_CTRL_MCS];
        end
      end
      if (enterLimp) begin
        savBcsp_q <= ctrl_q[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL];
        savMcs_q <= ctrl_q[`PLHCC_CTRL_MCS];
        ctrl_q[`PLHCC_CTRL_PLL_POWER_ON] <= 1'b1; // [R12]
        ctrl_q[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL] <= 1'b1;
        ctrl_q[`PLHCC_CTRL_MCS] <= 1'b0;
      end
      if (leaveLimp) begin
        ctrl_q[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL] <= savBcsp_q; // [R16]
        ctrl_q[`PLHCC_CTRL_MCS] <= savMcs_q;
      end
      track_q <= trackNext;
      lock_q <= lockNext;
      if (flagWr) begin
        lock_irq_enable_q <= regWdata[`PLHCC_FLAG_LOCK_IRQ_ENABLE];
        limp_home_irq_enable_q <= regWdata[`PLHCC_FLAG_LIMP_HOME_IRQ_ENABLE];
      end
      // Write one to clear; a new event wins
      lockIf_q <= (lockNext != lock_q) | (lockIf_q & ~(flagWr & regWdata[`PLHCC_FLAG_LOCKIF]));
      limp_home_irq_flag_q <= (lhomeNext != limp_home_active_q) | (limp_home_irq_flag_q & ~(flagWr & regWdata[`PLHCC_FLAG_LIMP_HOME_IRQ_FLAG])); // [R13]
      limp_home_active_q <= lhomeNext; // [R13] [R20]
      if (regWr && regAddr == `PLHCC_REG_STOP)
        dly_q <= regWdata[`PLHCC_STOP_DLY];
      case (state_q)
        ST_PORST: begin
          if (midHit && (extClockPresent || lhomeNext)) // [R19] [R9]
            state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (stopReq && !lossReset)
            state_q <= ST_STOP;
        end
        ST_STOP: begin
          if (wake)
            state_q <= dly_q ? ST_EXIT : ST_RUN; // [R22] [R24]
        end
        ST_EXIT: begin
          if (midHit)
            state_q <= ST_RUN; // [R22]
        end
        default: state_q <= ST_PORST;
      endcase
    end
  end

  // Latch survives only the reset it caused; clears once reset is left
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      noLimpLatch_q <= 1'b0;
    else if (lossReset && limpAvail)
      noLimpLatch_q <= 1'b1; // [R11]
    else if (rstN && state_q == ST_RUN)
      noLimpLatch_q <= 1'b0;
  end

  always @* begin
    cntClear = 1'b0;
    if (state_q == ST_STOP && wake)
      cntClear = 1'b1;
    if (state_q == ST_PORST && midHit && extClockPresent)
      cntClear = 1'b1; // [R19]
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 8'h00;
      filterTrack <= 1'b0;
      pllPowerOn <= 1'b0;
      busClockFromPll <= 1'b0;
      moduleClockSelect <= 1'b0;
      forcePclkAll <= 1'b0;
      monitorActive <= 1'b0;
      intResetN <= 1'b0;
      monitorReset <= 1'b0;
      lockIrq <= 1'b0;
      limpIrq <= 1'b0;
      stopped <= 1'b0;
    end else begin
      regRdata <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `PLHCC_REG_CTRL: regRdata <= {ctrl_q[7:2], track_q, ctrl_q[0]};
          `PLHCC_REG_FLAG: regRdata <= {1'b0, track_q, limp_home_irq_enable_q, limp_home_irq_flag_q, limp_home_active_q, lock_irq_enable_q,
            lockIf_q, lock_q};
          `PLHCC_REG_STOP: regRdata <= {6'h00, stopped, dly_q};
          default: regRdata <= 8'h00;
        endcase
      end
      filterTrack <= track_q;
      pllPowerOn <= (ctrl_q[`PLHCC_CTRL_PLL_POWER_ON] | forceLimp) & pllSupply;
      busClockFromPll <= ctrl_q[`PLHCC_CTRL_BUS_CLOCK_FROM_PLL] | forceLimp; // [R12]
      moduleClockSelect <= ctrl_q[`PLHCC_CTRL_MCS] & ~forceLimp;
      forcePclkAll <= forceLimp; // [R14]
      monitorActive <= monEn;
      intResetN <= (state_q != ST_PORST); // [R19]
      monitorReset <= lossReset; // [R11]
      lockIrq <= lockIf_q & lock_irq_enable_q; // [R4]
      limpIrq <= limp_home_irq_flag_q & limp_home_irq_enable_q; // [R13]
      stopped <= (state_q == ST_STOP) | (state_q == ST_EXIT);
    end
  end
endmodule
`default_nettype wire

/* hw/plhcc_map.vh */
// Constants for the PLL limp-home clock control block.
// Assumes inclusion by bare name from the design files.
//
// Overview of operation
// R1: Auto mode: detector switches filter acquisition/tracking
// R2: Auto mode: track select read-only, hardware driven
// R3: Lock flag read-only, set/cleared by tolerance
// R4: Lock toggle requests interrupt when enabled
// R5: Manual mode keeps lock detection, no switching
// R6: Manual mode: written track select drives filter
// R7: Software clears track select before PLL on
// R8: Limp-home from minimum VCO needs PLL supply
// R9: Power-up limp-home only in normal modes
// R10: Monitor detects reference loss when enabled
// R11: Limp disabled: loss resets, latch blocks limp
// R12: Limp enabled: loss forces VCO minimum clocks
// R13: Limp-home active change sets flag, interrupt
// R14: In limp-home monitor forced, clocks forced
// R15: Poll monitor at count 4096, every 8192
// R16: Clock back: exit limp, restore saved selects
// R17: Software clears bus-clock-from-pll during limp
// R18: Reset sets monitor, PLL on, clears disable
// R19: Power-up reset lasts until count 4096
// R20: No clock: release reset in limp-home
// R21: No PLL supply: external clock only
// R22: Stop-exit delay enable gives 4096-count delay
// R23: Stop left on reset, IRQs, wake-ups
// R24: Monitor off: stop exits on external clock; here any wake input exits stop, external clock not checked
`ifndef PLHCC_MAP_VH
`define PLHCC_MAP_VH
`define PLHCC_ADDR_W 3
`define PLHCC_REG_CTRL 3'h0
`define PLHCC_REG_FLAG 3'h1
`define PLHCC_REG_STOP 3'h2
// Control register fields
`define PLHCC_CTRL_AUTO 0
`define PLHCC_CTRL_TRACK 1
`define PLHCC_CTRL_PLL_POWER_ON 2
`define PLHCC_CTRL_CME 3
`define PLHCC_CTRL_FORCED_MONITOR_ENABLE 4
`define PLHCC_CTRL_NOLH 5
`define PLHCC_CTRL_BUS_CLOCK_FROM_PLL 6
`define PLHCC_CTRL_MCS 7
`define PLHCC_CTRL_RESET 8'h1D
// Flag register fields
`define PLHCC_FLAG_LOCK 0
`define PLHCC_FLAG_LOCKIF 1
`define PLHCC_FLAG_LOCK_IRQ_ENABLE 2
`define PLHCC_FLAG_LIMP_HOME_ACTIVE 3
`define PLHCC_FLAG_LIMP_HOME_IRQ_FLAG 4
`define PLHCC_FLAG_LIMP_HOME_IRQ_ENABLE 5
`define PLHCC_FLAG_TRACK 6
// Stop register fields
`define PLHCC_STOP_DLY 0
`define PLHCC_STOP_ACT 1
// Counter
`define PLHCC_CNT_W 13
`define PLHCC_CNT_MID 13'h1000
`endif

/* hw/plhcc_divider.v */
// Slow timebase enable divider.
// Assumes one clock; a new divisor takes effect at once, not only on wrap.
`timescale 1ns/1ps
`default_nettype none
module plhcc_divider (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Control
  input wire [5:0] divSel,
  // Output pulse
  output reg tick
);
  reg [7:0] cnt_q;
  wire [7:0] lim = (divSel == 6'h00) ? 8'h00 : {divSel, 2'b00} - 8'h01;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hw/plhcc_counter.v */
// 13-stage free-running counter with mid-count pulse.
// Assumes tick is a one-cycle enable at slow timebase rate.
`timescale 1ns/1ps
`default_nettype none
`include "plhcc_map.vh"
module plhcc_counter (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Control
  input wire tick,
  input wire clear,
  // Status
  output reg midHit
);
  reg [`PLHCC_CNT_W-1:0] cnt_q;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= {`PLHCC_CNT_W{1'b0}};
      midHit <= 1'b0;
    end else if (clear) begin
      cnt_q <= {`PLHCC_CNT_W{1'b0}};
      midHit <= 1'b0;
    end else begin
      midHit <= 1'b0;
      if (tick) begin
        cnt_q <= cnt_q + 13'h0001;
        // Mid-count, so every 8192 ticks [R15]
        if (cnt_q == `PLHCC_CNT_MID - 13'h0001)
          midHit <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/plhcc_ext_source.sv */
// External clock source model: reports clock activity.
// Assumes oscOn comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module plhcc_ext_source #(parameter int STARTUP = 8) (
  // Control and status
  input wire logic ref_clk,
  input wire logic oscOn,
  output var logic extClockPresent
);
  int run = 0;
  initial extClockPresent = 1'b0;
  // Crystal start-up: activity shows only after settling
  always @(posedge ref_clk) begin
    run <= oscOn ? run + 1 : 0;
    extClockPresent <= oscOn && run >= STARTUP;
  end
endmodule
`default_nettype wire

/* tb/plhcc_checker.sv */
// Checker for the clock control top ports.
// Assumes binding to plhcc_top.
`timescale 1ns/1ps
`default_nettype none
module plhcc_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic stopReq,
  input wire logic extClockPresent,
  input wire logic pllSupply,
  input wire logic forcePclkAll,
  input wire logic pllPowerOn,
  input wire logic busClockFromPll,
  input wire logic moduleClockSelect,
  input wire logic monitorActive,
  input wire logic monitorReset,
  input wire logic intResetN,
  input wire logic stopped
);
  int lowCnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 0;
    end else if (!intResetN && lowCnt < 20000) begin
      lowCnt <= lowCnt + 1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence limpLeave;
    forcePclkAll ##1 !forcePclkAll;
  endsequence
  sequence limpEnter;
    !forcePclkAll ##1 forcePclkAll;
  endsequence
  limp_steer_a: assert property (
    forcePclkAll && intResetN |-> pllPowerOn && busClockFromPll && !moduleClockSelect)
    else $error("limp steering wrong");
  limp_monitor_a: assert property (
    forcePclkAll |-> monitorActive) else $error("monitor off in limp");
  no_supply_a: assert property (
    !pllSupply [*2] |-> !forcePclkAll) else $error("limp without supply");
  limp_exit_a: assert property (
    limpLeave |-> $past(extClockPresent)) else $error("limp left without clock");
  limp_entry_a: assert property (
    limpEnter |-> !$past(extClockPresent) || !$past(intResetN, 2))
    else $error("limp entered with clock");
  reset_len_a: assert property (
    $rose(intResetN) |-> lowCnt inside {[16380:16400]}) else $error("reset length wrong");
  loss_reset_a: assert property (
    monitorReset |-> !forcePclkAll) else $error("reset and limp together");
  stop_entry_a: assert property (
    $rose(stopped) |-> $past(stopReq) || $past(stopReq, 2)) else $error("stop unasked");
endmodule
bind plhcc_top plhcc_checker i_plhcc_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .stopReq(stopReq),
  .extClockPresent(extClockPresent), .pllSupply(pllSupply),
  .forcePclkAll(forcePclkAll), .pllPowerOn(pllPowerOn),
  .busClockFromPll(busClockFromPll), .moduleClockSelect(moduleClockSelect),
  .monitorActive(monitorActive), .monitorReset(monitorReset),
  .intResetN(intResetN), .stopped(stopped)
);
`default_nettype wire

/* tb/pll_limp_home_clock_control_tb.sv */
// Bench for the clock control block: limp-home, lock, filter, stop.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "plhcc_map.vh"
module pll_limp_home_clock_control_tb;
  logic ref_clk = 0, rst_n = 0, regWr = 0, regRd = 0, oscOn = 0, stopReq = 0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, rd, regRdata;
  logic vcoInTrack = 0, vcoOutUntrack = 0, vcoInLock = 0, vcoOutUnlock = 0;
  logic [5:0] wake = 6'h00;
  logic pllSupply = 1, normalMode = 1;
  logic extClockPresent, filterTrack, pllPowerOn, busClockFromPll, moduleClockSelect;
  logic forcePclkAll, monitorActive, intResetN, monitorReset, lockIrq, limpIrq, stopped;
  int mismatches = 0, checked = 0, cyc = 0;
  plhcc_ext_source i_plhcc_ext_source (.ref_clk(ref_clk), .oscOn(oscOn),
    .extClockPresent(extClockPresent));
  plhcc_top i_plhcc_top (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .vcoInTrack(vcoInTrack), .vcoOutUntrack(vcoOutUntrack), .vcoInLock(vcoInLock),
    .vcoOutUnlock(vcoOutUnlock), .pllSupply(pllSupply), .normalMode(normalMode),
    .extClockPresent(extClockPresent), .slowDiv(6'h01), .stopReq(stopReq),
    .extResetWake(wake[0]), .maskIrqWake(wake[1]), .nmiPinWake(wake[2]),
    .keyWakeA(wake[3]), .keyWakeB(wake[4]), .canWake(wake[5]),
    .filterTrack(filterTrack), .pllPowerOn(pllPowerOn), .busClockFromPll(busClockFromPll),
    .moduleClockSelect(moduleClockSelect), .forcePclkAll(forcePclkAll),
    .monitorActive(monitorActive), .intResetN(intResetN), .monitorReset(monitorReset),
    .lockIrq(lockIrq), .limpIrq(limpIrq), .stopped(stopped));
  always #2.5 ref_clk = ~ref_clk;
  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, sized above the longest polling waits
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= w;
    regRd <= !w;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return forcePclkAll;
      1: return intResetN;
      2: return monitorReset;
      default: return stopped;
    endcase
  endfunction
  task automatic waitFor(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(pick(k), v);
  endtask
  initial begin
    int n;
    int i;
    logic b;
    void'($urandom(29));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    waitFor(1, 1'b1, 17000, n);
    chk(forcePclkAll, 1'b1);
    chk({pllPowerOn, busClockFromPll, moduleClockSelect, monitorActive}, 8'h0D);
    bus(1'b0, `PLHCC_REG_CTRL, 8'h00);
    chk(rd & 8'h3D, `PLHCC_CTRL_RESET);
    bus(1'b0, `PLHCC_REG_FLAG, 8'h00);
    chk(rd & 8'h18, 8'h18);
    bus(1'b1, `PLHCC_REG_FLAG, 8'h30);
    bus(1'b1, `PLHCC_REG_CTRL, 8'h1D);
    @(posedge ref_clk);
    oscOn <= 1'b1;
    waitFor(0, 1'b0, 33000, n);
    chk({limpIrq, busClockFromPll, moduleClockSelect}, 8'h04);
    bus(1'b0, `PLHCC_REG_FLAG, 8'h00);
    chk(rd & 8'h18, 8'h10);
    bus(1'b1, `PLHCC_REG_CTRL, 8'h0C);
    for (i = 0; i < 4; i++) begin
      b = 1'($urandom);
      @(posedge ref_clk);
      vcoInTrack <= 1'($urandom);
      bus(1'b1, `PLHCC_REG_CTRL, {6'h03, b, 1'b0});
      repeat (2) @(posedge ref_clk);
      #1;
      chk(filterTrack, b);
    end
    bus(1'b1, `PLHCC_REG_FLAG, 8'h06);
    for (i = 0; i < 4; i++) begin
      if (i == 2) bus(1'b1, `PLHCC_REG_CTRL, 8'h0D);
      @(posedge ref_clk);
      vcoInLock <= !i[0];
      vcoOutUnlock <= i[0];
      vcoInTrack <= !i[0];
      vcoOutUntrack <= i[0];
      repeat (3) @(posedge ref_clk);
      #1;
      chk(lockIrq, 1'b1);
      if (i > 1) chk(filterTrack, !i[0]);
      bus(1'b0, `PLHCC_REG_FLAG, 8'h00);
      chk(rd[`PLHCC_FLAG_LOCK], !i[0]);
      bus(1'b1, `PLHCC_REG_FLAG, 8'h06);
    end
    bus(1'b1, `PLHCC_REG_CTRL, 8'h25);
    for (i = 0; i < 7; i++) begin
      bus(1'b1, `PLHCC_REG_STOP, {7'h00, i == 6});
      stopReq <= 1'b1;
      @(posedge ref_clk);
      stopReq <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(stopped, 1'b1);
      chk(monitorActive, 1'b0);
      bus(1'b0, `PLHCC_REG_STOP, 8'h00);
      chk(rd, {6'h00, 1'b1, i == 6});
      @(posedge ref_clk);
      wake <= 6'h01 << (i % 6);
      waitFor(3, 1'b0, 17000, n);
      chk(n > 16000, i == 6);
      @(posedge ref_clk);
      wake <= 6'h00;
    end
    bus(1'b1, `PLHCC_REG_CTRL, 8'h2D);
    oscOn <= 1'b0;
    waitFor(2, 1'b1, 33000, n);
    chk(forcePclkAll, 1'b0);
    @(posedge ref_clk);
    pllSupply <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(pllPowerOn, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    pllSupply <= 1'b1;
    normalMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    // No clock and not a normal mode: reset must not end in limp-home
    repeat (17000) @(posedge ref_clk);
    #1;
    chk(intResetN, 1'b0);
    bus(1'b0, `PLHCC_REG_FLAG, 8'h00);
    chk(rd & 8'h18, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
